// File: bench/backplane_reader.sv
`timescale 1ns/10ps
module backplane_reader
(
  input wire logic clk_sys,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic [7:0] rd_index
);
  initial
  begin
    rd_req = 1'b0;
    rd_index = 8'h00;
  end
  // released index shows the inverse so a stale index can never look valid
  task automatic read_byte(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_index = idx;
    @(negedge clk_sys);
    rd_req = 1'b0;
    rd_index = ~idx;
    for (int i = 0; i < 4 && ok !== 1'b1; i++)
    begin
      ok = rd_valid;
      d = rd_data;
      if (ok !== 1'b1)
        @(negedge clk_sys);
    end
  endtask : read_byte
endmodule : backplane_reader

// File: bench/diag_record_checker.sv
`timescale 1ns/10ps
module diag_record_checker
  import diag_record_pkg::*;
#(
  parameter int CHANNELS = 2
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic module_fail,
  input wire logic internal_error,
  input wire logic external_error,
  input wire logic aux_supply_fault,
  input wire logic param_error,
  input wire logic diag_buf_overflow,
  input wire logic internal_comm_error,
  input wire logic [CHANNELS-1:0] channel_cfg_error,
  input wire logic [CHANNELS-1:0] channel_short,
  input wire logic [CHANNELS-1:0] short_enable,
  input wire logic rd_req,
  input wire logic [7:0] rd_index,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [CHANNELS-1:0] channel_led,
  input wire logic [TICKER_WIDTH-1:0] us_count
);
  // ****************************************
  // expected record bytes from live inputs
  // ****************************************
  wire logic [CHANNELS-1:0] ch_any = channel_cfg_error | (channel_short & short_enable);
  wire logic [7:0] sum_now = {param_error, 2'b00, aux_supply_fault, |ch_any, external_error,
    internal_error, module_fail};
  wire logic [7:0] det_now = {3'b000, internal_comm_error, diag_buf_overflow, 3'b000};
  wire logic [7:0] grp_now = 8'(ch_any);
  wire logic [7:0] ch0_now = {4'h0, channel_short[0] & short_enable[0], 2'b00,
    channel_cfg_error[0]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_valid; 1'b1 |=> (rd_valid == $past(rd_req)); endproperty
  a_valid: assert property (p_valid) else $error("read answer timing wrong");
  property p_count; rd_req && rd_index == IDX_CHANNEL_COUNT |=> rd_data == 8'h02; endproperty
  a_count: assert property (p_count) else $error("channel count byte wrong");
  property p_kind; rd_req && rd_index == IDX_CHANNEL_KIND |=> rd_data == 8'h73; endproperty
  a_kind: assert property (p_kind) else $error("channel kind byte wrong");
  // record lags inputs by one edge and the read answer by another
  property p_sum;
    rd_req && rd_index == IDX_ERROR_SUMMARY |=> rd_data == $past(sum_now, 2);
  endproperty
  a_sum: assert property (p_sum) else $error("summary byte wrong");
  property p_det;
    rd_req && rd_index == IDX_ERROR_DETAIL |=> rd_data == $past(det_now, 2);
  endproperty
  a_det: assert property (p_det) else $error("detail byte wrong");
  property p_grp;
    rd_req && rd_index == IDX_GROUP_ERRORS |=> rd_data == $past(grp_now, 2);
  endproperty
  a_grp: assert property (p_grp) else $error("group byte wrong");
  property p_ch0;
    rd_req && rd_index == IDX_CH0_ERRORS |=> rd_data == $past(ch0_now, 2);
  endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 byte wrong");
  property p_led; 1'b1 |=> channel_led == $past(ch_any); endproperty
  a_led: assert property (p_led) else $error("channel indicator wrong");
  property p_step; $changed(us_count) |-> us_count == $past(us_count) + 32'h1; endproperty
  a_step: assert property (p_step) else $error("ticker step wrong");
  property p_rate; $changed(us_count) |-> ##200 $changed(us_count); endproperty
  a_rate: assert property (p_rate) else $error("ticker rate wrong");
  c_stamp: cover property (rd_req && rd_index == IDX_TIMESTAMP_B3);
  c_led: cover property (channel_led[1]);
  c_param: cover property (rd_valid && rd_data == 8'h80);
endmodule : diag_record_checker
bind output_module_diag_record diag_record_checker #(.CHANNELS(CHANNELS)) diag_record_checker_i (.*);

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
  import diag_record_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] sum_in = 5'h00;
  logic [1:0] det_in = 2'h0;
  logic [1:0] cfg = 2'h0;
  logic [1:0] shrt = 2'h0;
  logic [1:0] en = 2'h0;
  logic rd_req;
  logic [7:0] rd_index;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [1:0] channel_led;
  logic [31:0] us_count;
  int errors = 0;
  int n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  output_module_diag_record output_module_diag_record_i (.clk_sys, .arst_n,
    .module_fail(sum_in[0]), .internal_error(sum_in[1]), .external_error(sum_in[2]),
    .aux_supply_fault(sum_in[3]), .param_error(sum_in[4]), .diag_buf_overflow(det_in[0]),
    .internal_comm_error(det_in[1]), .channel_cfg_error(cfg), .channel_short(shrt),
    .short_enable(en), .rd_req, .rd_index, .rd_data, .rd_valid, .channel_led, .us_count);
  backplane_reader backplane_reader_i (.clk_sys, .rd_valid, .rd_data, .rd_req, .rd_index);
  task complete_run;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    backplane_reader_i.read_byte(idx, d, ok);
    check("read answer", 32'h1, {31'h0, ok});
    if (ok !== 1'b1)
      complete_run;
    check($sformatf("byte %h", idx), {24'h0, exp}, {24'h0, d});
  endtask : rd_chk
  task wait_tick;
    logic [31:0] t;
    int n;
    t = us_count;
    n = 0;
    while (us_count === t && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300)
      check("ticker moves", 32'h1, 32'h0);
    if (n == 300)
      complete_run;
  endtask : wait_tick
  task ticker_start;
    check("ticker at release", 32'h0, us_count);
    wait_tick;
    check("first tick value", 32'h1, us_count);
  endtask : ticker_start
  task automatic idle_record;
    logic [7:0] idx [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h0C, 8'h17};
    logic [7:0] exp [12] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h73, 8'h08, 8'h02, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 12; i++)
      rd_chk(idx[i], exp[i]);
  endtask : idle_record
  task automatic error_bits;
    logic [7:0] exp [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80};
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk_sys);
      sum_in = 5'h01 << i;
      rd_chk(IDX_ERROR_SUMMARY, exp[i]);
    end
    sum_in = 5'h00;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_sys);
      det_in = 2'h1 << i;
      rd_chk(IDX_ERROR_DETAIL, 8'h08 << i);
    end
    det_in = 2'h0;
  endtask : error_bits
  task channel_bits;
    @(negedge clk_sys);
    cfg = 2'b01;
    rd_chk(IDX_CH0_ERRORS, 8'h01);
    rd_chk(IDX_GROUP_ERRORS, 8'h01);
    rd_chk(IDX_ERROR_SUMMARY, 8'h08);
    check("led cfg", 32'h1, {30'h0, channel_led});
    cfg = 2'b00;
    shrt = 2'b10;
    rd_chk(IDX_CH1_ERRORS, 8'h00);
    check("led masked", 32'h0, {30'h0, channel_led});
    en = 2'b10;
    rd_chk(IDX_CH1_ERRORS, 8'h08);
    rd_chk(IDX_GROUP_ERRORS, 8'h02);
    check("led short", 32'h2, {30'h0, channel_led});
    shrt = 2'b00;
    en = 2'b00;
  endtask : channel_bits
  task stamp;
    logic [31:0] t;
    // raising right after a tick leaves a long stable ticker window
    wait_tick;
    t = us_count;
    det_in = 2'b01;
    for (int i = 0; i < 4; i++)
      rd_chk(IDX_TIMESTAMP_B0 + 8'(i), t[8*i +: 8]);
    det_in = 2'b00;
  endtask : stamp
  initial
  begin
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    ticker_start;
    idle_record;
    error_bits;
    channel_bits;
    stamp;
    complete_run;
  end
endmodule : tb

// File: hw/diag_record_pkg.sv
package diag_record_pkg;

  // ****************************************************************
  // record byte indices
  // ****************************************************************
  localparam logic [7:0] IDX_ERROR_SUMMARY = 8'h02;
  localparam logic [7:0] IDX_MODULE_INFO = 8'h03;
  localparam logic [7:0] IDX_RESERVED_C = 8'h04;
  localparam logic [7:0] IDX_ERROR_DETAIL = 8'h05;
  localparam logic [7:0] IDX_CHANNEL_KIND = 8'h06;
  localparam logic [7:0] IDX_DIAG_BITS = 8'h07;
  localparam logic [7:0] IDX_CHANNEL_COUNT = 8'h08;
  localparam logic [7:0] IDX_GROUP_ERRORS = 8'h09;
  localparam logic [7:0] IDX_CH0_ERRORS = 8'h0A;
  localparam logic [7:0] IDX_CH1_ERRORS = 8'h0B;
  localparam logic [7:0] IDX_TIMESTAMP_B0 = 8'h13;
  localparam logic [7:0] IDX_TIMESTAMP_B1 = 8'h14;
  localparam logic [7:0] IDX_TIMESTAMP_B2 = 8'h15;
  localparam logic [7:0] IDX_TIMESTAMP_B3 = 8'h16;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SUM_MODULE_FAIL = 0;
  localparam int SUM_INTERNAL = 1;
  localparam int SUM_EXTERNAL = 2;
  localparam int SUM_CHANNEL = 3;
  localparam int SUM_AUX_SUPPLY = 4;
  localparam int SUM_PARAM = 7;
  localparam int DET_BUF_OVERFLOW = 3;
  localparam int DET_COMM_ERROR = 4;
  localparam int CH_CFG_ERROR = 0;
  localparam int CH_SHORT_GND = 3;

  // ****************************************************************
  // constant record contents
  // ****************************************************************
  localparam logic [3:0] MODULE_CLASS_ANALOG = 4'h5;
  localparam int MODINFO_CH_PRESENT = 4;
  localparam logic [6:0] KIND_DIGITAL_IN = 7'h70;
  localparam logic [6:0] KIND_ANALOG_IN = 7'h71;
  localparam logic [6:0] KIND_DIGITAL_OUT = 7'h72;
  localparam logic [6:0] KIND_ANALOG_OUT = 7'h73;
  localparam logic [6:0] KIND_ANALOG_IO = 7'h74;
  localparam logic [6:0] KIND_COUNTER = 7'h76;
  localparam logic [7:0] DIAG_BITS_VALUE = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_PS = 1000000;
  localparam int CYCLES_PER_US = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TICKER_WIDTH = 32;

endpackage : diag_record_pkg

// File: hw/output_module_diag_record.sv
// Behaviour
// R01: summary bit0 module failure, bit1 internal, bit2 external, bit3 channel error.
// R02: summary bit4 set when external auxiliary supply is faulty.
// R03: summary bit7 set on erroneous parameter assignment; bits 6..5 reserved.
// R04: module info reads class 0101b, bit4 channel info present, rest reserved.
// R05: detail byte bit3 set on internal diagnostics buffer overflow.
// R06: detail byte bit4 set on internal communication error; other bits reserved.
// R07: channel kind byte holds 7-bit code; this module reports analog output 73h.
// R08: diagnostic bits per channel byte reads 08h.
// R09: channel count byte reads 02h.
// R10: group error byte bit0 for group 0, bit1 for group 1.
// R11: per-channel byte bit0 set on configuration or parameter error.
// R12: per-channel byte bit3 set on output short to ground.
// R13: timestamp holds ticker value latched when a diagnostic is recorded.
// R14: microsecond ticker starts from zero at power-on, one step per microsecond.
// R15: ticker is 32 bits and wraps to zero, continuing.
// R16: every error is recorded and lights its channel indicator; no interrupt.
// R17: shorts reported only on channels whose recognition enable bit is 1.
// R18: reserved bits of every diagnostic byte read zero.
// R19: any per-channel error sets channel summary bit and matching group bit.
`timescale 1ns/10ps
module output_module_diag_record
  import diag_record_pkg::*;
#(
  parameter int CHANNELS = 2
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic module_fail,
  input wire logic internal_error,
  input wire logic external_error,
  input wire logic aux_supply_fault,
  input wire logic param_error,
  input wire logic diag_buf_overflow,
  input wire logic internal_comm_error,
  input wire logic [CHANNELS-1:0] channel_cfg_error,
  input wire logic [CHANNELS-1:0] channel_short,
  input wire logic [CHANNELS-1:0] short_enable,
  input wire logic rd_req,
  input wire logic [7:0] rd_index,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [CHANNELS-1:0] channel_led,
  output logic [TICKER_WIDTH-1:0] us_count
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] error_summary;
    logic [7:0] error_detail;
    logic [7:0] channel_group_errors;
    logic [7:0] channel0_errors;
    logic [7:0] channel1_errors;
    logic [TICKER_WIDTH-1:0] diag_timestamp;
    logic [CHANNELS-1:0] led;
    logic [7:0] rd_data;
    logic rd_valid;
  } record_state_t;

  record_state_t state;
  record_state_t next_state;
  logic [TICKER_WIDTH-1:0] ticker;

  // ****************************************************************
  // microsecond ticker
  // ****************************************************************
  us_ticker #(
    .DIVIDE(CYCLES_PER_US),
    .WIDTH(TICKER_WIDTH)
  ) u_ticker (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .count(ticker)
  );

  // ****************************************************************
  // constant bytes
  // ****************************************************************
  logic [7:0] module_info;
  logic [7:0] channel_kind;

  always_comb
  begin
    module_info = BYTE_ZERO; // [R18]
    module_info[3:0] = MODULE_CLASS_ANALOG; // [R04]
    module_info[MODINFO_CH_PRESENT] = 1'b1; // [R04]
    channel_kind = {1'b0, KIND_ANALOG_OUT}; // [R07] [R18]
  end

  // ****************************************************************
  // record update and read port
  // ****************************************************************
  always_comb
  begin
    logic [7:0] ch_byte [CHANNELS];
    logic [7:0] group;
    logic any_channel;
    logic new_error;
    ch_byte = '{default: BYTE_ZERO};
    group = BYTE_ZERO;
    any_channel = 1'b0;
    new_error = 1'b0;
    next_state = state;

    for (int i = 0; i < CHANNELS; i++)
    begin
      ch_byte[i][CH_CFG_ERROR] = channel_cfg_error[i]; // [R11]
      // a short on a channel without recognition enabled stays silent
      ch_byte[i][CH_SHORT_GND] = channel_short[i] & short_enable[i]; // [R12] [R17]
      group[i] = |ch_byte[i]; // [R10] [R19]
      any_channel = any_channel | group[i]; // [R19]
    end

    next_state.channel0_errors = ch_byte[0];
    next_state.channel1_errors = ch_byte[1];
    next_state.channel_group_errors = group;
    next_state.led = group[CHANNELS-1:0]; // [R16]

    next_state.error_summary = BYTE_ZERO; // [R18]
    next_state.error_summary[SUM_MODULE_FAIL] = module_fail; // [R01]
    next_state.error_summary[SUM_INTERNAL] = internal_error; // [R01]
    next_state.error_summary[SUM_EXTERNAL] = external_error; // [R01]
    next_state.error_summary[SUM_CHANNEL] = any_channel; // [R01] [R19]
    next_state.error_summary[SUM_AUX_SUPPLY] = aux_supply_fault; // [R02]
    next_state.error_summary[SUM_PARAM] = param_error; // [R03]

    next_state.error_detail = BYTE_ZERO; // [R18]
    next_state.error_detail[DET_BUF_OVERFLOW] = diag_buf_overflow; // [R05]
    next_state.error_detail[DET_COMM_ERROR] = internal_comm_error; // [R06]

    // a diagnostic is recorded when any error bit newly rises
    new_error = |(next_state.error_summary & ~state.error_summary)
      | |(next_state.error_detail & ~state.error_detail)
      | |(next_state.channel0_errors & ~state.channel0_errors)
      | |(next_state.channel1_errors & ~state.channel1_errors);
    if (new_error)
    begin
      next_state.diag_timestamp = ticker; // [R13]
    end

    // reads see the record as it stood before this edge
    next_state.rd_valid = rd_req;
    next_state.rd_data = state.rd_data;
    if (rd_req)
    begin
      case (rd_index)
        IDX_ERROR_SUMMARY: next_state.rd_data = state.error_summary;
        IDX_MODULE_INFO: next_state.rd_data = module_info;
        IDX_ERROR_DETAIL: next_state.rd_data = state.error_detail;
        IDX_CHANNEL_KIND: next_state.rd_data = channel_kind;
        IDX_DIAG_BITS: next_state.rd_data = DIAG_BITS_VALUE; // [R08]
        IDX_CHANNEL_COUNT: next_state.rd_data = CHANNEL_COUNT_VALUE; // [R09]
        IDX_GROUP_ERRORS: next_state.rd_data = state.channel_group_errors;
        IDX_CH0_ERRORS: next_state.rd_data = state.channel0_errors;
        IDX_CH1_ERRORS: next_state.rd_data = state.channel1_errors;
        IDX_TIMESTAMP_B0: next_state.rd_data = state.diag_timestamp[7:0];
        IDX_TIMESTAMP_B1: next_state.rd_data = state.diag_timestamp[15:8];
        IDX_TIMESTAMP_B2: next_state.rd_data = state.diag_timestamp[23:16];
        IDX_TIMESTAMP_B3: next_state.rd_data = state.diag_timestamp[31:24];
        // reserved bytes and unmapped indices read zero
        default: next_state.rd_data = BYTE_ZERO; // [R18]
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rd_data = state.rd_data;
  assign rd_valid = state.rd_valid;
  assign channel_led = state.led; // [R16]
  assign us_count = ticker;

endmodule : output_module_diag_record

// File: hw/us_ticker.sv
`timescale 1ns/10ps
module us_ticker
  import diag_record_pkg::*;
#(
  parameter int DIVIDE = CYCLES_PER_US,
  parameter int WIDTH = TICKER_WIDTH
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  output logic [WIDTH-1:0] count
);

  typedef struct packed
  {
    logic [15:0] prescale;
    logic [WIDTH-1:0] count;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (state.prescale == 16'(DIVIDE - 1))
    begin
      next_state.prescale = 16'h0000;
      // plain binary add wraps past all-ones back to zero [R15]
      next_state.count = state.count + 1'b1; // [R14]
    end
    else
    begin
      next_state.prescale = state.prescale + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0; // [R14]
    end
    else
    begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule : us_ticker
